// *** design/dam_mode_ctrl.sv ***
// Addressing-mode control for both address generators
module dam_mode_ctrl
   import dam_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Register bus
   input  wire logic [3:0]        reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_we_i,
   input  wire logic              reg_re_i,
   output      logic [31:0]       reg_rdata_o,
   // Sequencer events
   input  wire logic              irq_entry_i,
   // Memory access path
   input  wire dam_acc_req_t      acc_req_i,
   output      dam_acc_rsp_t      acc_rsp_o,
   // Register move path
   input  wire dam_mv_req_t       mv_req_i,
   output      dam_dwr_t          dwr_o,
   // Current mode bits
   output wire logic [31:0]       mode_o
);

   localparam int AW = DAM_AW;

   // Step size per access width
   function automatic logic [AW-1:0] step_of(input dam_size_t sz);
      case (sz)
         SZ_SW:   step_of = K_SW;
         SZ_BW:   step_of = K_BW;
         default: step_of = K_NW;
      endcase
   endfunction

   // Mode and mask state
   logic [31:0]  mode_ff;
   logic [31:0]  mask_ff;
   logic [3:0]   alt_sel_ff;
   logic [31:0]  rdata_ff;
   logic [31:0]  nxt_mode;
   logic [31:0]  nxt_mask;

   // Generator register banks: [bank][number]
   logic [AW-1:0] i_ff [0:1][0:15];
   logic [AW-1:0] m_ff [0:1][0:15];
   logic [AW-1:0] l_ff [0:1][0:15];
   logic [AW-1:0] b_ff [0:1][0:15];

   // Answer registers
   dam_acc_rsp_t rsp_ff;
   dam_dwr_t     dwr_ff;

   // Bus decode
   wire logic mode_we;
   wire logic mask_we;
   wire logic [31:0] rd_mux;

   assign mode_we = reg_we_i && (reg_addr_i == OFF_MODE);
   assign mask_we = reg_we_i && (reg_addr_i == OFF_MASK);

   // Unmapped offsets read as zero
   assign rd_mux = (reg_addr_i == OFF_MODE) ? mode_ff :
                   (reg_addr_i == OFF_MASK) ? mask_ff :
                   (reg_addr_i == OFF_STAT) ? {28'h0000000, alt_sel_ff} :
                   32'h0000_0000;

   // Mode update; interrupt entry clears after a same-cycle write
   wire logic [31:0] mode_wr;
   wire logic [31:0] irq_clr;

   assign mode_wr  = mode_we ? (reg_wdata_i & MODE_USED) : mode_ff;
   assign irq_clr  = irq_entry_i ? (mask_ff & MASKABLE) : 32'h0000_0000;
   assign nxt_mode = mode_wr & ~irq_clr;
   assign nxt_mask = mask_we ? (reg_wdata_i & MASKABLE) : mask_ff;

   // Decoded mode bits
   wire logic bc1_en;
   wire logic bc2_en;
   wire logic br1_en;
   wire logic br2_en;
   wire logic dual_en;
   wire logic ext40_en;

   assign bc1_en   = mode_ff[B_BCAST1];
   assign bc2_en   = mode_ff[B_BCAST2];
   assign br1_en   = mode_ff[B_BREV1];
   assign br2_en   = mode_ff[B_BREV2];
   assign dual_en  = mode_ff[B_DUAL];
   assign ext40_en = mode_ff[B_EXT40];
   assign mode_o   = mode_ff;

   // Access operand fetch from the active bank of each group
   wire logic          acc_bank;
   wire logic          mdf_bank;
   wire logic [3:0]    mdf_num;
   wire logic [AW-1:0] idx_val;
   wire logic [AW-1:0] mdf_val;
   wire logic [AW-1:0] step;

   assign acc_bank = alt_sel_ff[acc_req_i.idx[3:2]];
   // Modifier always from the same generator as the index
   assign mdf_num  = {acc_req_i.idx[3], acc_req_i.mdf[2:0]};
   assign mdf_bank = alt_sel_ff[mdf_num[3:2]];
   assign idx_val  = i_ff[acc_bank][acc_req_i.idx];
   assign mdf_val  = m_ff[mdf_bank][mdf_num];
   assign step     = step_of(acc_req_i.size);

   // Address arithmetic
   wire logic [AW-1:0] ea;
   wire logic [AW-1:0] pair_ea;
   wire logic [AW-1:0] nxt_idx;
   wire logic [AW-1:0] ea_rev;

   dam_agen #(
      .W           (AW)
   ) u_agen (
      .index_i     (idx_val),
      .modify_i    (mdf_val),
      .step_i      (step),
      .pre_i       (acc_req_i.pre),
      .ea_o        (ea),
      .pair_o      (pair_ea),
      .nxt_index_o (nxt_idx)
   );

   dam_bitrev #(
      .W      (AW)
   ) u_bitrev (
      .addr_i (ea),
      .addr_o (ea_rev)
   );

   // Mode qualification of the access
   wire logic brev_hit;
   wire logic bcast_hit;
   wire logic pair_hit;
   wire logic acc_upd;

   assign brev_hit = (acc_req_i.idx == BR1_IDX && br1_en) ||
                     (acc_req_i.idx == BR2_IDX && br2_en);
   // Dual select deliberately absent from this term
   assign bcast_hit = acc_req_i.rd && acc_req_i.dreg &&
                      ((acc_req_i.idx == BC1_IDX && bc1_en) ||
                       (acc_req_i.idx == BC2_IDX && bc2_en));
   assign pair_hit = dual_en && !ext40_en && !bcast_hit &&
                     (acc_req_i.size != SZ_BW) && !acc_req_i.lw;
   assign acc_upd  = acc_req_i.valid && !acc_req_i.pre;

   // Move path decode
   wire logic          mv_dag;
   wire logic          mv_out;
   wire logic          mv_bank;
   wire logic          mv_wi;
   wire logic [AW-1:0] mv_rd;

   // Into generator: explicit only, first element condition
   assign mv_dag  = mv_req_i.valid && mv_req_i.to_dag &&
                    mv_req_i.cond_first;
   assign mv_out  = mv_req_i.valid && !mv_req_i.to_dag;
   assign mv_bank = alt_sel_ff[mv_req_i.num[3:2]];
   // Base load also loads the index
   assign mv_wi   = mv_dag && (mv_req_i.kind == RK_I ||
                               mv_req_i.kind == RK_B);
   assign mv_rd   = (mv_req_i.kind == RK_M) ? m_ff[mv_bank][mv_req_i.num] :
                    (mv_req_i.kind == RK_L) ? l_ff[mv_bank][mv_req_i.num] :
                    (mv_req_i.kind == RK_B) ? b_ff[mv_bank][mv_req_i.num] :
                    i_ff[mv_bank][mv_req_i.num];

   // Index write port: move wins over a same-cycle post-modify
   wire logic          wi_en;
   wire logic          wi_bank;
   wire logic [3:0]    wi_num;
   wire logic [AW-1:0] wi_data;

   assign wi_en   = mv_wi || acc_upd;
   assign wi_bank = mv_wi ? mv_bank : acc_bank;
   assign wi_num  = mv_wi ? mv_req_i.num : acc_req_i.idx;
   assign wi_data = mv_wi ? mv_req_i.data : nxt_idx;

   // Mode, mask and bus read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_ff  <= MODE_RST;
         mask_ff  <= MASK_RST;
         rdata_ff <= 32'h0000_0000;
      end else begin
         mode_ff  <= nxt_mode;
         mask_ff  <= nxt_mask;
         rdata_ff <= reg_re_i ? rd_mux : 32'h0000_0000;
      end
   end

   // Extra stage so a set change lands one cycle after the mode write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alt_sel_ff <= 4'h0;
      end else begin
         alt_sel_ff <= mode_ff[B_ALT +: 4];
      end
   end

   // Generator registers; only the addressed bank is touched
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int b = 0; b < 2; b++) begin
            for (int n = 0; n < 16; n++) begin
               i_ff[b][n] <= 32'h0000_0000;
               m_ff[b][n] <= 32'h0000_0000;
               l_ff[b][n] <= 32'h0000_0000;
               b_ff[b][n] <= 32'h0000_0000;
            end
         end
      end else begin
         if (wi_en) begin
            i_ff[wi_bank][wi_num] <= wi_data;
         end
         if (mv_dag && mv_req_i.kind == RK_M) begin
            m_ff[mv_bank][mv_req_i.num] <= mv_req_i.data;
         end
         if (mv_dag && mv_req_i.kind == RK_L) begin
            l_ff[mv_bank][mv_req_i.num] <= mv_req_i.data;
         end
         if (mv_dag && mv_req_i.kind == RK_B) begin
            b_ff[mv_bank][mv_req_i.num] <= mv_req_i.data;
         end
      end
   end

   // Address answer, one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff.valid     <= acc_req_i.valid;
         rsp_ff.rd        <= acc_req_i.rd;
         rsp_ff.addr      <= brev_hit ? ea_rev : ea;
         rsp_ff.pair_en   <= acc_req_i.valid && pair_hit;
         rsp_ff.pair_addr <= pair_ea;
         rsp_ff.dup_en    <= acc_req_i.valid && bcast_hit;
         rsp_ff.dnum      <= acc_req_i.dnum;
      end
   end

   // Data register write from a generator register move
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dwr_ff <= '0;
      end else begin
         dwr_ff.wr_first  <= mv_out;
         dwr_ff.wr_second <= mv_out && dual_en;
         dwr_ff.dnum      <= mv_req_i.dnum;
         dwr_ff.data      <= mv_rd;
      end
   end

   // Outputs from flops
   assign reg_rdata_o = rdata_ff;
   assign acc_rsp_o   = rsp_ff;
   assign dwr_o       = dwr_ff;

endmodule // dam_mode_ctrl

// *** design/dam_pkg.sv ***
// Shared constants, types and carriers for the addressing-mode control block
package dam_pkg;

   // Address and data word width
   localparam int DAM_AW = 32;

   // Register bus offsets (byte addresses)
   localparam logic [3:0] OFF_MODE = 4'h0;
   localparam logic [3:0] OFF_MASK = 4'h4;
   localparam logic [3:0] OFF_STAT = 4'h8;

   // Bit positions inside mode_control_word
   localparam int B_BCAST1 = 0;
   localparam int B_BCAST2 = 1;
   localparam int B_BREV1  = 2;
   localparam int B_BREV2  = 3;
   localparam int B_DUAL   = 4;
   localparam int B_ALT    = 5;  // four alternate selects, bits 5..8
   localparam int B_CIRC   = 9;
   localparam int B_EXT40  = 10;

   // Reset values and masking
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [31:0] MODE_USED = 32'h0000_07FF;
   localparam logic [31:0] MASKABLE  = 32'h0000_03EF;

   // Index registers with special meaning
   localparam logic [3:0] BC1_IDX = 4'h1;
   localparam logic [3:0] BC2_IDX = 4'h9;
   localparam logic [3:0] BR1_IDX = 4'h0;
   localparam logic [3:0] BR2_IDX = 4'h8;

   // Implicit address steps per word size
   localparam logic [DAM_AW-1:0] K_NW = 32'h0000_0001;
   localparam logic [DAM_AW-1:0] K_SW = 32'h0000_0002;
   localparam logic [DAM_AW-1:0] K_BW = 32'h0000_0004;

   typedef enum logic [1:0] {
      SZ_NW = 2'b00,
      SZ_SW = 2'b01,
      SZ_BW = 2'b10
   } dam_size_t;

   typedef enum logic [1:0] {
      RK_I = 2'b00,
      RK_M = 2'b01,
      RK_L = 2'b10,
      RK_B = 2'b11
   } dam_rkind_t;

   // Memory access request from the sequencer
   typedef struct packed {
      logic              valid;
      logic              rd;
      logic              pre;
      logic              lw;
      logic              dreg;
      dam_size_t         size;
      logic [3:0]        idx;
      logic [3:0]        mdf;
      logic [3:0]        dnum;
   } dam_acc_req_t;

   // Address answer towards memory and register files
   typedef struct packed {
      logic              valid;
      logic              rd;
      logic [DAM_AW-1:0] addr;
      logic              pair_en;
      logic [DAM_AW-1:0] pair_addr;
      logic              dup_en;
      logic [3:0]        dnum;
   } dam_acc_rsp_t;

   // Register move between generator and data registers
   typedef struct packed {
      logic              valid;
      logic              to_dag;
      logic              cond_first;
      dam_rkind_t        kind;
      logic [3:0]        num;
      logic [3:0]        dnum;
      logic [DAM_AW-1:0] data;
   } dam_mv_req_t;

   // Data register write towards both elements
   typedef struct packed {
      logic              wr_first;
      logic              wr_second;
      logic [3:0]        dnum;
      logic [DAM_AW-1:0] data;
   } dam_dwr_t;

endpackage

// *** design/dam_bitrev.sv ***
// Bit-order reversal of one address word
module dam_bitrev #(
   parameter int W = 32
) (
   // Address in and out
   input  wire logic [W-1:0] addr_i,
   output wire logic [W-1:0] addr_o
);

   // Width check
   if (W < 2) begin : g_chk
      $error("dam_bitrev: W must be at least 2");
   end

   // Bit n goes to bit W-1-n
   for (genvar n = 0; n < W; n++) begin : g_rev
      assign addr_o[W-1-n] = addr_i[n];
   end

endmodule // dam_bitrev

// *** design/dam_agen.sv ***
// Effective, paired and updated index computation for one access
module dam_agen #(
   parameter int W = 32
) (
   // Operands
   input  wire logic [W-1:0] index_i,
   input  wire logic [W-1:0] modify_i,
   input  wire logic [W-1:0] step_i,
   input  wire logic         pre_i,
   // Results
   output wire logic [W-1:0] ea_o,
   output wire logic [W-1:0] pair_o,
   output wire logic [W-1:0] nxt_index_o
);

   // Width check
   if (W < 8) begin : g_chk
      $error("dam_agen: W must be at least 8");
   end

   wire logic [W-1:0] sum;

   // Sum uses the stored, never reversed, index
   assign sum         = index_i + modify_i;
   assign ea_o        = pre_i ? sum : index_i;
   assign nxt_index_o = pre_i ? index_i : sum;
   // Odd or even explicit address, same step
   assign pair_o      = ea_o + step_i;

endmodule // dam_agen

// *** test/dam_mode_ctrl_properties.sv ***
// Concurrent checks on the addressing-mode control ports
module dam_mode_ctrl_properties
   import dam_pkg::*;
(
   // Clock, reset and register bus
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire logic [3:0]   reg_addr_i,
   input wire logic [31:0]  reg_wdata_i,
   input wire logic         reg_we_i,
   input wire logic         reg_re_i,
   input wire logic [31:0]  reg_rdata_o,
   // Events, paths and mode
   input wire logic         irq_entry_i,
   input wire dam_acc_req_t acc_req_i,
   input wire dam_acc_rsp_t acc_rsp_o,
   input wire dam_mv_req_t  mv_req_i,
   input wire dam_dwr_t     dwr_o,
   input wire logic [31:0]  mode_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Reference reversal, bit n to bit 31-n, kept apart from the design's wiring
   function automatic logic [31:0] flip(input logic [31:0] a);
      for (int n = 0; n < 32; n++) flip[n] = a[31 - n];
   endfunction

   // Mask shadow, so interrupt entry can be predicted from the ports
   logic [31:0] msk_ff;
   logic [31:0] keep_w;
   logic        plain_w;
   logic        bc_w;
   assign keep_w  = mode_o & ~msk_ff;
   assign plain_w = mode_o[B_DUAL] && !mode_o[B_EXT40] && mode_o[3:0] == 4'h0;
   assign bc_w    = (acc_req_i.idx == BC1_IDX && mode_o[B_BCAST1])
                 || (acc_req_i.idx == BC2_IDX && mode_o[B_BCAST2]);
   always_ff @(posedge clk_i)
      if (rst_i) msk_ff <= '0;
      else if (reg_we_i && reg_addr_i == OFF_MASK) msk_ff <= reg_wdata_i & MASKABLE;

   mode_write_a:
   assert property (reg_we_i && reg_addr_i == OFF_MODE && !irq_entry_i
      |=> mode_o == ($past(reg_wdata_i) & MODE_USED)) else $error("mode write lost");
   irq_clear_a:
   assert property (irq_entry_i && !reg_we_i |=> mode_o == $past(keep_w))
      else $error("interrupt entry clear wrong");
   rev_addr_a:
   assert property (acc_req_i.valid && !acc_req_i.pre && !acc_req_i.lw
      && mode_o[B_DUAL] && !mode_o[B_EXT40] && acc_req_i.size == SZ_NW
      && ((acc_req_i.idx == BR1_IDX && mode_o[B_BREV1])
      || (acc_req_i.idx == BR2_IDX && mode_o[B_BREV2]))
      |=> acc_rsp_o.addr == flip(acc_rsp_o.pair_addr - 32'h1)) else $error("reversal wrong");
   pair_step_a:
   assert property (acc_req_i.valid && plain_w && !acc_req_i.lw && acc_req_i.size != SZ_BW
      |=> acc_rsp_o.pair_en && acc_rsp_o.pair_addr == acc_rsp_o.addr
      + ($past(acc_req_i.size) == SZ_SW ? K_SW : K_NW)) else $error("pair address wrong");
   no_pair_a:
   assert property (acc_req_i.valid && (!mode_o[B_DUAL] || mode_o[B_EXT40] || acc_req_i.lw
      || acc_req_i.size == SZ_BW || (bc_w && acc_req_i.rd && acc_req_i.dreg))
      |=> !acc_rsp_o.pair_en) else $error("pairing not overridden");
   dup_load_a:
   assert property (acc_req_i.valid && acc_req_i.rd && acc_req_i.dreg && bc_w
      |=> acc_rsp_o.valid && acc_rsp_o.dup_en) else $error("broadcast missing");
   no_dup_a:
   assert property (acc_req_i.valid && !(acc_req_i.rd && acc_req_i.dreg && bc_w)
      |=> !acc_rsp_o.dup_en) else $error("broadcast unexpected");
   move_copy_a:
   assert property (mv_req_i.valid && !mv_req_i.to_dag
      |=> dwr_o.wr_first && dwr_o.wr_second == $past(mode_o[B_DUAL]))
      else $error("move copy wrong");
   move_in_a:
   assert property (mv_req_i.valid && mv_req_i.to_dag |=> !dwr_o.wr_first && !dwr_o.wr_second)
      else $error("move into generator wrote data");
endmodule // dam_mode_ctrl_properties

bind dam_mode_ctrl dam_mode_ctrl_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
   .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_entry_i(irq_entry_i),
   .acc_req_i(acc_req_i), .acc_rsp_o(acc_rsp_o), .mv_req_i(mv_req_i), .dwr_o(dwr_o),
   .mode_o(mode_o));

// *** test/dam_regfile_model.sv ***
// Data register files of both elements behind a fixed-content memory
module dam_regfile_model
   import dam_pkg::*;
(
   // Clock and design answers
   input wire logic         clk_i,
   input wire dam_acc_rsp_t acc_rsp_i,
   input wire dam_dwr_t     dwr_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] rf_first [16];
   logic [31:0] rf_second [16];

   // Known start so a missed copy never matches by accident
   initial foreach (rf_first[i]) begin
      rf_first[i] = '0;
      rf_second[i] = '0;
   end

   // Memory word is a fixed scramble of its address
   function automatic logic [31:0] mem_word(input logic [31:0] a);
      return a ^ 32'hC3A5_0F96;
   endfunction

   // Loads and moves land in the named register and, when flagged, its complement
   always @(posedge clk_i) begin
      if (acc_rsp_i.valid && acc_rsp_i.rd) begin
         rf_first[acc_rsp_i.dnum] <= mem_word(acc_rsp_i.addr);
         if (acc_rsp_i.dup_en) rf_second[acc_rsp_i.dnum] <= mem_word(acc_rsp_i.addr);
         else if (acc_rsp_i.pair_en) rf_second[acc_rsp_i.dnum] <= mem_word(acc_rsp_i.pair_addr);
      end
      if (dwr_i.wr_first) rf_first[dwr_i.dnum] <= dwr_i.data;
      if (dwr_i.wr_second) rf_second[dwr_i.dnum] <= dwr_i.data;
   end
endmodule // dam_regfile_model

// *** test/dam_mode_ctrl_tb.sv ***
// Self-checking bench for the addressing-mode control block
module dam_mode_ctrl_tb
   import dam_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clk_i = 1'b0;
   logic         rst_i = 1'b1;
   logic [3:0]   reg_addr_i = '0;
   logic [31:0]  reg_wdata_i = '0;
   logic         reg_we_i = 1'b0;
   logic         reg_re_i = 1'b0;
   logic         irq_entry_i = 1'b0;
   dam_acc_req_t acc_req_i = '0;
   dam_mv_req_t  mv_req_i = '0;
   logic [31:0]  reg_rdata_o;
   logic [31:0]  mode_o;
   dam_acc_rsp_t acc_rsp_o;
   dam_acc_rsp_t rsp;
   dam_dwr_t     dwr_o;
   int           err_count = 0;
   int           num_checks = 0;
   int           seed = 32'h5a73;
   logic [31:0]  va, vb, vm, q;

   // Clock and instances
   always #5 clk_i = ~clk_i;
   dam_mode_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
      .reg_rdata_o(reg_rdata_o), .irq_entry_i(irq_entry_i), .acc_req_i(acc_req_i),
      .acc_rsp_o(acc_rsp_o), .mv_req_i(mv_req_i), .dwr_o(dwr_o), .mode_o(mode_o));
   dam_regfile_model u_model (.clk_i(clk_i), .acc_rsp_i(acc_rsp_o), .dwr_i(dwr_o));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // One register cycle; read data taken in the cycle after the strobe
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= we;
      reg_re_i <= !we;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
      reg_re_i <= 1'b0;
      #1 r = reg_rdata_o;
   endtask

   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, '0, r);
      chk("rdata", exp, r);
   endtask

   task automatic acc(input logic rd, pre, lw, dreg, input dam_size_t sz,
                      input logic [3:0] idx, mdf, dn);
      @(posedge clk_i);
      acc_req_i <= '{1'b1, rd, pre, lw, dreg, sz, idx, mdf, dn};
      @(posedge clk_i);
      acc_req_i <= '0;
      #1 rsp = acc_rsp_o;
   endtask

   task automatic mv(input logic to, cf, input dam_rkind_t k, input logic [3:0] n,
                     input logic [31:0] d);
      @(posedge clk_i);
      mv_req_i <= '{1'b1, to, cf, k, n, 4'h3, d};
      @(posedge clk_i);
      mv_req_i <= '0;
      #1;
   endtask

   function automatic logic [31:0] rev(input logic [31:0] a);
      for (int i = 0; i < 32; i++) rev[i] = a[31 - i];
   endfunction

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      print_verdict();
   end

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(OFF_MODE, MODE_RST);
      rchk(4'hC, 32'h0);
      // Bit-reversed emission with plain stored index, both generators
      for (int g = 0; g < 2; g++) begin
         va = $random(seed);
         vm = $random(seed) & 32'h0FFF;
         mv(1, 1, RK_I, 4'(g * 8), va);
         mv(1, 1, RK_M, 4'(g * 8 + 1), vm);
         bus(1, OFF_MODE, (32'h4 << g) | 32'h10, q);
         acc(1, 0, 0, 1, SZ_NW, 4'(g * 8), 4'(g * 8 + 1), 4'h2);
         chk("rev addr", rev(va), rsp.addr);
         acc(1, 0, 0, 1, SZ_NW, 4'(g * 8), 4'(g * 8 + 1), 4'h2);
         chk("rev next", rev(va + vm), rsp.addr);
         mv(0, 1, RK_I, 4'(g * 8), '0);
         chk("index", va + (vm << 1), dwr_o.data);
         chk("dual copy", 1, dwr_o.wr_second);
      end
      // Pre/post modify with pairing per word size, even and odd index
      bus(1, OFF_MODE, 32'h10, q);
      for (int j = 0; j < 6; j++) begin
         va = ($random(seed) & 32'hFFFF_FFFE) | (j / 3);
         vm = $random(seed) & 32'h0FFF;
         mv(1, 1, RK_I, 4'h3, va);
         mv(1, 1, RK_M, 4'h2, vm);
         acc(1, 1, 0, 1, dam_size_t'(j % 3), 4'h3, 4'h2, 4'h4);
         chk("pre addr", va + vm, rsp.addr);
         chk("pair en", (j % 3) != 2, rsp.pair_en);
         if (j % 3 != 2) chk("pair addr", va + vm + (32'h1 << (j % 3)), rsp.pair_addr);
         acc(1, 0, 0, 1, dam_size_t'(j % 3), 4'h3, 4'h2, 4'h4);
         chk("post addr", va, rsp.addr);
         acc(1, 0, 1, 1, SZ_NW, 4'h3, 4'h2, 4'h4);
         chk("lw pair", 0, rsp.pair_en);
         chk("post upd", va + vm, rsp.addr);
      end
      // Forty-bit mode and single-data mode give no pair
      for (int j = 0; j < 2; j++) begin
         bus(1, OFF_MODE, j ? 32'h0 : 32'h410, q);
         acc(1, 0, 0, 1, SZ_NW, 4'h3, 4'h2, 4'h4);
         chk("no pair", 0, rsp.pair_en);
      end
      // Broadcast in both modes; stores and universal registers get no broadcast
      for (int j = 0; j < 4; j++) begin
         bus(1, OFF_MODE, 32'h3 | ((j & 1) << 4), q);
         mv(1, 1, RK_B, 4'(j / 2 * 8 + 1), $random(seed));
         acc(1, 0, 0, 1, SZ_NW, 4'(j / 2 * 8 + 1), 4'(j / 2 * 8), 4'(j + 5));
         chk("dup", 1, rsp.dup_en);
         chk("bc pair", 0, rsp.pair_en);
         @(posedge clk_i);
         #1;
         chk("copy", u_model.rf_first[j + 5], u_model.rf_second[j + 5]);
         acc(0, 0, 0, 1, SZ_NW, 4'(j / 2 * 8 + 1), 4'(j / 2 * 8), 4'h6);
         chk("store", 0, rsp.dup_en);
         chk("store rd", 0, rsp.rd);
         acc(1, 0, 0, 0, SZ_NW, 4'(j / 2 * 8 + 1), 4'(j / 2 * 8), 4'h6);
         chk("ureg", 0, rsp.dup_en);
      end
      // Move into generator obeys the first element condition only
      bus(1, OFF_MODE, 32'h10, q);
      va = $random(seed);
      mv(1, 1, RK_I, 4'h5, va);
      mv(1, 0, RK_I, 4'h5, ~va);
      mv(0, 1, RK_I, 4'h5, '0);
      chk("cond move", va, dwr_o.data);
      chk("move dnum", 32'h3, dwr_o.dnum);
      // Alternate sets per group; spacing after mode write kept by the bus task
      for (int g = 0; g < 4; g++) begin
         va = $random(seed);
         vb = $random(seed);
         bus(1, OFF_MODE, '0, q);
         mv(1, 1, RK_I, 4'(4 * g), va);
         bus(1, OFF_MODE, 32'h20 << g, q);
         mv(1, 1, RK_I, 4'(4 * g), vb);
         mv(0, 1, RK_I, 4'(4 * g), '0);
         chk("alt", vb, dwr_o.data);
         rchk(OFF_STAT, 32'h1 << g);
         bus(1, OFF_MODE, '0, q);
         mv(0, 1, RK_I, 4'(4 * g), '0);
         chk("primary", va, dwr_o.data);
      end
      // Interrupt entry clears masked bits; first pass all ones
      for (int j = 0; j < 3; j++) begin
         va = j ? $random(seed) : 32'hFFFF_FFFF;
         vb = j ? $random(seed) : 32'hFFFF_FFFF;
         bus(1, OFF_MODE, va, q);
         bus(1, OFF_MASK, vb, q);
         rchk(OFF_MASK, vb & MASKABLE);
         @(posedge clk_i);
         irq_entry_i <= 1'b1;
         @(posedge clk_i);
         irq_entry_i <= 1'b0;
         rchk(OFF_MODE, va & MODE_USED & ~(vb & MASKABLE));
      end
      print_verdict();
   end
endmodule // dam_mode_ctrl_tb
